// file: design/kbenc_map.svh
// Timing counts, line counts and code constants of the keyboard encoder.
`ifndef KBENC_MAP_SVH
`define KBENC_MAP_SVH
`define KBENC_ROW_LINES 8
`define KBENC_COL_LINES 7
`define KBENC_KEY_CODES 56
`define KBENC_CLK_MHZ 250
`define KBENC_RELEASE_MS 50
`define KBENC_RELEASE_CYCLES (`KBENC_RELEASE_MS * 1000 * `KBENC_CLK_MHZ)
`define KBENC_ASCII_BASE 7'h20
`endif

// file: design/kbenc_pkg.sv
// Types shared by the keyboard encoder modules.
package kbenc_pkg;
    typedef enum logic [6:0] {
        KBENC_LOAD   = 7'h01,
        KBENC_CLR2   = 7'h02,
        KBENC_XFER   = 7'h04,
        KBENC_CMP    = 7'h08,
        KBENC_OFFER  = 7'h10,
        KBENC_HELD   = 7'h20,
        KBENC_TIMING = 7'h40
    } kbenc_state_e;
    typedef logic [6:0] kbenc_ascii_t;
endpackage : kbenc_pkg

// file: design/kbenc_conv_if.sv
// Link between the second buffer and the final code converter.
`timescale 1ns/10ps
interface kbenc_conv_if #(parameter int ROW_W = 3, parameter int COL_W = 3);
    logic [ROW_W-1:0] row_idx;
    logic [COL_W-1:0] col_idx;
    logic [6:0] ascii;
    modport encoder (output row_idx, output col_idx, input ascii);
    modport converter (input row_idx, input col_idx, output ascii);
endinterface : kbenc_conv_if

// file: design/kbenc_code_conv.sv
// Final converter from row and column index to the ASCII character.
`timescale 1ns/10ps
`include "kbenc_map.svh"
module kbenc_code_conv import kbenc_pkg::*; #(
    parameter int COL_LINES = `KBENC_COL_LINES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    kbenc_conv_if.converter conv
);
    kbenc_ascii_t ascii_r;
    kbenc_ascii_t ascii_nxt;

    // Each row contributes a fixed offset and each column a fixed step.
    assign ascii_nxt = 7'(int'(`KBENC_ASCII_BASE) + int'(conv.row_idx) * COL_LINES
                          + int'(conv.col_idx));

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ascii_r <= 7'h00;
        end else if (ce_in) begin
            ascii_r <= ascii_nxt;
        end
    end

    assign conv.ascii = ascii_r;
endmodule : kbenc_code_conv

// file: design/kbenc_encoder.sv
// Keyboard encoder: two comparing buffers, multi-key inhibit and release debounce.
`timescale 1ns/10ps
`include "kbenc_map.svh"
module kbenc_encoder import kbenc_pkg::*; #(
    parameter int ROW_LINES = `KBENC_ROW_LINES,
    parameter int COL_LINES = `KBENC_COL_LINES,
    parameter int RELEASE_CYCLES = `KBENC_RELEASE_CYCLES
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    input wire logic SENSE_LEADING_PULSE_IN,
    input wire logic SENSE_STROBE_IN,
    input wire logic [ROW_LINES+COL_LINES-1:0] SENSE_LINES_IN,
    input wire logic SCAN_DONE_IN,
    input wire logic KEY_FEEDBACK_IN,
    output logic [6:0] CHAR_OUT,
    output logic CHAR_VALID_OUT,
    output logic LOAD_ENABLE_OUT
);
    localparam int LINES = ROW_LINES + COL_LINES;
    localparam int ROW_W = (ROW_LINES > 1) ? $clog2(ROW_LINES) : 1;
    localparam int COL_W = (COL_LINES > 1) ? $clog2(COL_LINES) : 1;
    localparam int TMR_W = $clog2(RELEASE_CYCLES);

    if (ROW_LINES * COL_LINES != `KBENC_KEY_CODES || RELEASE_CYCLES < 2) begin : g_bad_cfg
        $error("kbenc_encoder: unsupported line count or release count");
    end

    kbenc_state_e state_r;
    kbenc_state_e state_nxt;
    logic [LINES-1:0] buf1_r;
    logic [LINES-1:0] buf2_r;
    logic [LINES-1:0] xlat;
    logic load_en_r;
    logic valid_r;
    logic [TMR_W-1:0] tmr_r;

    // The new board wires the lines in reverse order within each group.
    for (genvar i = 0; i < LINES; i++) begin : g_xlat
        if (i < ROW_LINES) begin : g_row
            assign xlat[i] = SENSE_LINES_IN[ROW_LINES-1-i];
        end else begin : g_col
            assign xlat[i] = SENSE_LINES_IN[LINES-1-(i-ROW_LINES)];
        end
    end

    wire single_key = ($countones(buf1_r[ROW_LINES-1:0]) == 1)
                      && ($countones(buf1_r[LINES-1:ROW_LINES]) == 1);
    wire no_key = (buf1_r == '0);
    wire bufs_equal = (buf1_r == buf2_r);
    wire frame_single = SCAN_DONE_IN && single_key;
    wire frame_any = SCAN_DONE_IN && !no_key;
    wire frame_none = SCAN_DONE_IN && no_key;
    wire tmr_done = (tmr_r == TMR_W'(RELEASE_CYCLES - 1));
    wire clear_buf1 = load_en_r && SENSE_LEADING_PULSE_IN;
    wire fill_buf1 = load_en_r && SENSE_STROBE_IN && !SENSE_LEADING_PULSE_IN;
    wire to_clr2 = (state_nxt == KBENC_CLR2) && (state_r != KBENC_CLR2);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            KBENC_LOAD: begin
                // Multi-key frames are ignored so no false code escapes.
                if (frame_single) begin
                    state_nxt = KBENC_CLR2;
                end
            end
            KBENC_CLR2: begin
                state_nxt = KBENC_XFER;
            end
            KBENC_XFER: begin
                state_nxt = KBENC_CMP;
            end
            KBENC_CMP: begin
                state_nxt = bufs_equal ? KBENC_OFFER : KBENC_CLR2;
            end
            KBENC_OFFER: begin
                if (KEY_FEEDBACK_IN) begin
                    state_nxt = KBENC_HELD;
                end
            end
            KBENC_HELD: begin
                // A different single key left after a rollover is a new character.
                if (frame_none) begin
                    state_nxt = KBENC_TIMING;
                end else if (frame_single && !bufs_equal) begin
                    state_nxt = KBENC_CLR2;
                end
            end
            KBENC_TIMING: begin
                if (frame_single) begin
                    state_nxt = bufs_equal ? KBENC_HELD : KBENC_CLR2;
                end else if (frame_any) begin
                    state_nxt = KBENC_HELD;
                end else if (tmr_done) begin
                    state_nxt = KBENC_LOAD;
                end
            end
            default: begin
                state_nxt = KBENC_LOAD;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r <= KBENC_LOAD;
        end else if (CE_IN) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            buf1_r <= '0;
        end else if (CE_IN) begin
            if (clear_buf1) begin
                buf1_r <= '0;
            end else if (fill_buf1) begin
                buf1_r <= buf1_r | xlat;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            buf2_r <= '0;
        end else if (CE_IN) begin
            if (state_r == KBENC_CLR2) begin
                buf2_r <= '0;
            end else if (state_r == KBENC_XFER) begin
                buf2_r <= buf1_r;
            end else if (state_r == KBENC_TIMING && state_nxt == KBENC_LOAD) begin
                buf2_r <= '0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            load_en_r <= 1'b1;
        end else if (CE_IN) begin
            if (to_clr2) begin
                load_en_r <= 1'b0;
            end else if (state_r == KBENC_CMP && bufs_equal) begin
                load_en_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            valid_r <= 1'b0;
        end else if (CE_IN) begin
            if (state_r == KBENC_CMP && bufs_equal) begin
                valid_r <= 1'b1;
            end else if (state_r == KBENC_OFFER && KEY_FEEDBACK_IN) begin
                valid_r <= 1'b0;
            end
        end
    end

    // The count is zeroed on the edge that leaves the interval, so a bounce restarts it at once.
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tmr_r <= '0;
        end else if (CE_IN) begin
            if (state_r == KBENC_TIMING && state_nxt == KBENC_TIMING) begin
                tmr_r <= tmr_r + TMR_W'(1);
            end else begin
                tmr_r <= '0;
            end
        end
    end

    function automatic int unsigned onehot_idx(input logic [LINES-1:0] v, input int lo,
                                               input int n);
        int unsigned idx;
        idx = 0;
        for (int k = 0; k < n; k++) begin
            if (v[lo+k]) begin
                idx = k;
            end
        end
        return idx;
    endfunction : onehot_idx

    kbenc_conv_if #(.ROW_W(ROW_W), .COL_W(COL_W)) conv ();

    assign conv.row_idx = ROW_W'(onehot_idx(buf2_r, 0, ROW_LINES));
    assign conv.col_idx = COL_W'(onehot_idx(buf2_r, ROW_LINES, COL_LINES));

    kbenc_code_conv #(.COL_LINES(COL_LINES)) u_conv (
        .clk_in(CORE_CLK_IN),
        .reset_n_in(RESET_N_IN),
        .ce_in(CE_IN),
        .conv(conv)
    );

    assign CHAR_OUT = conv.ascii;
    assign CHAR_VALID_OUT = valid_r;
    assign LOAD_ENABLE_OUT = load_en_r;

    default clocking cb @(posedge CORE_CLK_IN iff CE_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    sequence s_clear2;
        state_r == KBENC_CLR2 && !load_en_r;
    endsequence
    sequence s_copy;
        state_r == KBENC_XFER && buf2_r == '0;
    endsequence

    a_leading_clears_buf: assert property (clear_buf1 |=> buf1_r == '0)
        else $error("leading pulse did not clear buffer one");
    a_translate_fill: assert property (fill_buf1
                                       |=> buf1_r == ($past(buf1_r) | $past(xlat)))
        else $error("translated data not gated into buffer one");
    a_frozen_buffer: assert property (!load_en_r && !SENSE_LEADING_PULSE_IN
                                      |=> $stable(buf1_r))
        else $error("buffer one altered while frozen");
    a_multi_no_char: assert property (state_r == KBENC_LOAD && SCAN_DONE_IN && !single_key
                                      |=> state_r == KBENC_LOAD && load_en_r)
        else $error("multi-key frame started a character");
    a_clear_then_copy: assert property (state_r == KBENC_LOAD && frame_single
                                        |=> s_clear2 ##1 s_copy ##1 buf2_r == buf1_r)
        else $error("clear and transfer sequence broken");
    a_compare_reload: assert property (state_r == KBENC_CMP && bufs_equal
                                       |=> load_en_r && CHAR_VALID_OUT)
        else $error("matching compare did not reload");
    a_char_offered: assert property ($rose(CHAR_VALID_OUT) |-> CHAR_OUT ==
        7'(int'(`KBENC_ASCII_BASE) + int'(conv.row_idx) * COL_LINES + int'(conv.col_idx)))
        else $error("offered character does not match buffer two");
    a_valid_until_fb: assert property (CHAR_VALID_OUT && !KEY_FEEDBACK_IN
                                       |=> CHAR_VALID_OUT)
        else $error("character withdrawn before feedback");
    a_release_clear: assert property (state_r == KBENC_TIMING && tmr_done && !frame_any
                                      |=> state_r == KBENC_LOAD && buf2_r == '0)
        else $error("buffer two not cleared after release interval");
    a_bounce_reject: assert property (state_r == KBENC_TIMING && frame_single && bufs_equal
                                      |=> state_r == KBENC_HELD && $stable(buf2_r)
                                          && tmr_r == '0)
        else $error("bounce not rejected");
    a_timer_bound: assert property (tmr_r <= TMR_W'(RELEASE_CYCLES - 1))
        else $error("release timer passed its terminal count");
endmodule : kbenc_encoder

// file: verif/kbenc_printer_model.sv
// Printer-side model that accepts offered characters and answers with feedback.
`timescale 1ns/10ps
module kbenc_printer_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic char_valid_in,
    output logic feedback_out
);
    int wait_r;
    // A random pause of up to three cycles shows both prompt and slow printers.
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            feedback_out <= 1'b0;
            wait_r <= 0;
        end else if (feedback_out) begin
            feedback_out <= 1'b0;
            wait_r <= $urandom_range(3);
        end else if (char_valid_in) begin
            if (wait_r == 0) begin
                feedback_out <= 1'b1;
            end else begin
                wait_r <= wait_r - 1;
            end
        end
    end
endmodule : kbenc_printer_model

// file: verif/keyboard_encoder_debounce_test.sv
// Self-checking bench for the keyboard encoder driven against the printer model.
`timescale 1ns/10ps
module keyboard_encoder_debounce_test import kbenc_pkg::*;;
    localparam int REL = 20;
    localparam int LIMIT = 10000;
    logic clk, rst_n, ce, lead, strobe, done, fb, valid, load_en;
    logic valid_d = 1'b0;
    logic [14:0] lines;
    logic [6:0] char_seen;
    kbenc_ascii_t exp_q[$];
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int k, r, c, r2, c2;

    kbenc_encoder #(.RELEASE_CYCLES(REL)) uut (
        .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
        .SENSE_LEADING_PULSE_IN(lead), .SENSE_STROBE_IN(strobe), .SENSE_LINES_IN(lines),
        .SCAN_DONE_IN(done), .KEY_FEEDBACK_IN(fb), .CHAR_OUT(char_seen),
        .CHAR_VALID_OUT(valid), .LOAD_ENABLE_OUT(load_en)
    );
    kbenc_printer_model printer (
        .clk_in(clk), .reset_n_in(rst_n), .char_valid_in(valid), .feedback_out(fb)
    );

    function automatic logic [14:0] key(input int row, input int col);
        return (15'h0001 << (7 - row)) | (15'h0001 << (14 - col));
    endfunction : key

    task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic drive(input logic l, input logic s, input logic d, input logic [14:0] v);
        lead <= l;
        strobe <= s;
        done <= d;
        lines <= v;
        @(posedge clk);
    endtask : drive

    // A non-zero pre code is strobed first and must be wiped by the second leading pulse.
    task automatic frame(input logic [14:0] pre, input logic [14:0] data);
        if (pre != 15'h0000) begin
            drive(1'b1, 1'b0, 1'b0, ~pre);
            drive(1'b0, 1'b1, 1'b0, pre);
        end
        drive(1'b1, 1'b0, 1'b0, ~data);
        drive(1'b0, 1'b1, 1'b0, data);
        drive(1'b0, 1'b0, 1'b1, ~data);
        drive(1'b0, 1'b0, 1'b0, 15'($urandom));
    endtask : frame

    task automatic press(input int row, input int col, input logic emit);
        if (emit) begin
            exp_q.push_back(7'h20 + 7'(row * 7 + col));
        end
        frame(15'h0000, key(row, col));
        // Outputs are read on the falling edge, where they have settled.
        @(negedge clk);
        check("LOAD_ENABLE_OUT frozen", {6'h00, load_en}, {6'h00, !emit});
        tick(11);
        @(negedge clk);
        check("LOAD_ENABLE_OUT", {6'h00, load_en}, 7'h01);
        tick(1);
    endtask : press

    task automatic release_keys(input int n);
        frame(15'h0000, 15'h0000);
        tick(n);
    endtask : release_keys

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            $display("[FAIL] run exceeded its cycle budget");
            results();
        end
    end

    // Every rising edge of the offer takes the oldest note; an offer with none noted fails.
    always @(negedge clk) begin
        valid_d <= valid;
        if (valid === 1'b1 && valid_d === 1'b0) begin
            if (exp_q.size() == 0) begin
                check("unexpected CHAR_VALID_OUT", {6'h00, valid}, 7'h00);
            end else begin
                check("CHAR_OUT", char_seen, exp_q.pop_front());
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        lead = 1'b0;
        strobe = 1'b0;
        done = 1'b0;
        lines = 15'h0000;
        ce = 1'b1;
        void'($urandom(68281));
        tick(5);
        rst_n <= 1'b1;
        tick(2);
        for (k = 0; k < 56; k++) begin
            press(k / 7, k % 7, 1'b1);
            release_keys(REL + 6);
        end
        r = $urandom_range(7);
        c = $urandom_range(6);
        r2 = (r + 1 + $urandom_range(6)) % 8;
        c2 = $urandom_range(6);
        press(r, c, 1'b1);
        release_keys(REL + 6);
        press(r, c, 1'b1);
        release_keys(5);
        press(r, c, 1'b0);
        // With the clock enable low the release timer must stand still, so this is still bounce.
        release_keys(5);
        ce <= 1'b0;
        tick(REL + 6);
        ce <= 1'b1;
        press(r, c, 1'b0);
        release_keys(5);
        press(r2, c2, 1'b1);
        press(r, c, 1'b1);
        frame(15'h0000, key(r, c) | key(r2, c2));
        tick(12);
        release_keys(REL + 6);
        frame(15'h0000, key(r, c) | key(r2, c2));
        tick(12);
        exp_q.push_back(7'h20 + 7'(r2 * 7 + c2));
        frame(key(r, c), key(r2, c2));
        tick(12);
        release_keys(REL + 6);
        check("pending notes", 7'(exp_q.size()), 7'h00);
        results();
    end
endmodule : keyboard_encoder_debounce_test
